// ===== bench/mcr_cpu_model.sv
// Core-side model: measures the spacing of CPU clock enables
`timescale 1ns/10ps
module mcr_cpu_model (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       resetn,
  // Enable from the unit, measured gap back to the bench
  input  wire logic       cpu_tick_q,
  output logic [7:0]      tick_gap_q
);
  logic [7:0] since_q;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      since_q    <= 8'h00;
      tick_gap_q <= 8'h00;
    end else if (cpu_tick_q) begin
      since_q    <= 8'h00;
      tick_gap_q <= since_q + 8'h01;
    end else begin
      since_q <= since_q + 8'h01;
    end
  end
endmodule

// ===== bench/mcr_main_clock_properties.sv
// Port-level assertions for the main clock unit
`timescale 1ns/10ps
module mcr_main_clock_properties (
  // Clock and reset
  input wire logic                  ref_clk,
  input wire logic                  resetn,
  // Watched inputs
  input wire mcr_pkg::mcr_bus_req_t bus_req,
  input wire logic                  cpu_irq_masked,
  input wire logic                  halt_exit_irq,
  input wire logic                  pll_option,
  // Watched outputs
  input wire logic [7:0]            rd_data_q,
  input wire logic                  backup_pll_on_q,
  input wire logic                  clock_source_pick_q,
  input wire logic                  cpu_tick_q,
  input wire logic                  clk_out_q,
  input wire logic                  clk_out_oe_q,
  input wire logic                  overflow_irq_q,
  input wire logic                  wake_q,
  input wire logic                  active_halt_q,
  input wire logic                  full_halt_q
);
  import mcr_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  // Settled run with the pin enabled, skips halt entry and exit
  sequence s_clk_running;
    (clk_out_oe_q && !active_halt_q && !full_halt_q) [*3];
  endsequence
  sequence s_deep_halt;
    full_halt_q ##1 full_halt_q;
  endsequence
  sequence s_held_active;
    active_halt_q ##1 active_halt_q;
  endsequence

  chk_pick_needs_pll: assert property (
    clock_source_pick_q |-> backup_pll_on_q)
    else $error("pll source picked while pll off");
  chk_option_forces: assert property (
    pll_option |=> clock_source_pick_q && backup_pll_on_q)
    else $error("option strap did not force pll source");
  chk_irq_unmasked: assert property (
    overflow_irq_q |-> !$past(cpu_irq_masked))
    else $error("overflow irq while cpu mask active");
  chk_clkout_toggles: assert property (
    s_clk_running |-> clk_out_q != $past(clk_out_q))
    else $error("clock out pin not toggling");
  chk_clkout_halted: assert property (
    s_held_active |-> !clk_out_q)
    else $error("clock out pin active in active halt");
  chk_tick_frozen: assert property (
    s_deep_halt |-> !cpu_tick_q)
    else $error("cpu tick in full halt");
  // Wake rises as the halt flag falls, so look one cycle past the halt
  chk_halt_wake_src: assert property (
    s_deep_halt ##1 wake_q |-> $past(halt_exit_irq))
    else $error("full halt woken without exit interrupt");
  chk_read_idle: assert property (
    !$past(bus_req.rd) |-> rd_data_q == 8'h00)
    else $error("read data outside read answer cycle");
  chk_one_halt: assert property (
    !(active_halt_q && full_halt_q))
    else $error("both halt states at once");
endmodule

bind mcr_main_clock mcr_main_clock_properties i_mcr_main_clock_properties (.*);

// ===== bench/tb_mcr_main_clock.sv
// Self-checking bench for the main clock unit
`timescale 1ns/10ps
module tb_mcr_main_clock;
  import mcr_pkg::*;
  localparam int TBP [4] = '{16, 32, 80, 200};
  localparam int THALF [4] = '{0, 4, 8, 16};
  localparam logic [7:0] SRC_W [5] = '{8'h02, 8'h0a, 8'h02, 8'h08, 8'h00};
  localparam logic [7:0] SRC_E [5] = '{8'h00, 8'h0a, 8'h0a, 8'h08, 8'h00};
  logic         ref_clk = 1'b0;
  logic         resetn = 1'b0;
  mcr_bus_req_t bus_req = '0;
  logic         halt_req = 1'b0, wait_mode = 1'b0, cpu_irq_masked = 1'b0, halt_exit_irq = 1'b0;
  logic         pll_option = 1'b0, in_circuit_programming_session = 1'b0, adc_irq_raw = 1'b0;
  logic [7:0]   rd_data_q, tick_gap_q;
  logic         backup_pll_on_q, clock_detector_q, clock_source_pick_q, cpu_tick_q, clk_out_q;
  logic         clk_out_oe_q, beep_q, beep_oe_q, overflow_irq_q, wake_q, active_halt_q;
  logic         full_halt_q, adc_sample_stretch_q, adc_irq_q, irq_d;
  int           cyc, rises, rise_at, mismatches, tests_run, h;
  int           t [4];

  mcr_main_clock #(
    .TB_PERIOD_0(TBP[0]), .TB_PERIOD_1(TBP[1]), .TB_PERIOD_2(TBP[2]), .TB_PERIOD_3(TBP[3]),
    .TONE_HALF_1(THALF[1]), .TONE_HALF_2(THALF[2]), .TONE_HALF_3(THALF[3])
  ) i_mcr_main_clock (.*);
  mcr_cpu_model i_mcr_cpu_model (
    .ref_clk(ref_clk), .resetn(resetn), .cpu_tick_q(cpu_tick_q), .tick_gap_q(tick_gap_q)
  );

  always #20 ref_clk = ~ref_clk;

  // Stamps each rise of the overflow interrupt
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    irq_d <= overflow_irq_q;
    if (overflow_irq_q === 1'b1 && irq_d !== 1'b1) begin
      rises <= rises + 1;
      rise_at <= cyc;
    end
  end

  task automatic check(input string w, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", w, exp, seen);
    end
  endtask
  task automatic flag(input string w, input logic seen, input logic exp);
    check(w, {7'h00, seen}, {7'h00, exp});
  endtask
  task automatic done(input string w);
    $display("test %s done", w);
  endtask
  // Whole-byte writes only
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    bus_req.wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string w);
    @(posedge ref_clk);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    bus_req.rd <= 1'b0;
    #1 check(w, rd_data_q, exp);
  endtask
  task automatic wait_rise(output int at);
    int n0;
    n0 = rises;
    for (int n = 0; n < 1000 && rises == n0; n++) begin
      @(posedge ref_clk);
      #1;
    end
    check("irq rise", 8'(rises - n0), 8'h01);
    at = rise_at;
  endtask
  task automatic halt_pulse;
    @(posedge ref_clk);
    halt_req <= 1'b1;
    @(posedge ref_clk);
    halt_req <= 1'b0;
  endtask
  // Cycles between the second and third beep edges
  task automatic half(output int hc);
    logic b;
    int n;
    n = 0;
    for (int k = 0; k < 3; k++) begin
      b = beep_q;
      hc = 0;
      while (beep_q === b && n < 200) begin
        @(posedge ref_clk);
        #1 hc++;
        n++;
      end
    end
  endtask
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    repeat (10000) @(posedge ref_clk);
    mismatches++;
    finish_test;
  end

  initial begin
    repeat (20) @(posedge ref_clk);
    resetn <= 1'b1;
    rd(MCR_OFS_CTRL_STATUS, MCR_RST_CTRL_STATUS, "status");
    rd(MCR_OFS_BEEP_CTRL, MCR_RST_BEEP_CTRL, "beep");
    rd(MCR_OFS_SOURCE, MCR_RST_SOURCE, "source");
    rd(8'h10, 8'h00, "unmapped");
    flag("tick", cpu_tick_q, 1'b1);
    done("reset");
    for (int i = 0; i < 5; i++) begin
      wr(MCR_OFS_SOURCE, SRC_W[i]);
      rd(MCR_OFS_SOURCE, SRC_E[i], "source");
      flag("pll", backup_pll_on_q, SRC_E[i][3]);
      flag("detector", clock_detector_q, SRC_E[i][3]);
      flag("pick", clock_source_pick_q, SRC_E[i][1]);
    end
    @(posedge ref_clk);
    pll_option <= 1'b1;
    wr(MCR_OFS_SOURCE, 8'h00);
    rd(MCR_OFS_SOURCE, 8'h0a, "option");
    @(posedge ref_clk);
    pll_option <= 1'b0;
    wr(MCR_OFS_SOURCE, 8'h08);
    wr(MCR_OFS_SOURCE, 8'h00);
    rd(MCR_OFS_SOURCE, 8'h00, "source");
    @(posedge ref_clk);
    in_circuit_programming_session <= 1'b1;
    repeat (2) @(posedge ref_clk);
    #1 flag("session pll", backup_pll_on_q, 1'b1);
    flag("session pick", clock_source_pick_q, 1'b1);
    wr(MCR_OFS_SOURCE, 8'h08);
    rd(MCR_OFS_SOURCE, 8'h08, "session");
    done("source");
    for (int c = 0; c < 4; c++) begin
      wr(MCR_OFS_CTRL_STATUS, 8'h10 | 8'(c << 5));
      repeat (40) @(posedge ref_clk);
      #1 check("gap", tick_gap_q, 8'(2 << c));
    end
    wr(MCR_OFS_CTRL_STATUS, 8'h00);
    repeat (4) @(posedge ref_clk);
    #1 check("gap", tick_gap_q, 8'h01);
    done("prescaler");
    for (int c = 0; c < 4; c++) begin
      wr(MCR_OFS_CTRL_STATUS, 8'(c << 2) | 8'h02);
      for (int k = 0; k < 4; k++) begin
        wait_rise(t[k]);
        rd(MCR_OFS_CTRL_STATUS, 8'(c << 2) | 8'h03, "status");
      end
      check("period", 8'(t[3] - t[2]), 8'(TBP[c]));
    end
    wr(MCR_OFS_CTRL_STATUS, 8'h02);
    wait_rise(t[0]);
    check("old period", 8'(t[0] - t[3]), 8'(TBP[3]));
    rd(MCR_OFS_CTRL_STATUS, 8'h03, "status");
    rd(MCR_OFS_CTRL_STATUS, 8'h02, "cleared");
    wait_rise(t[1]);
    check("new period", 8'(t[1] - t[0]), 8'(TBP[0]));
    @(posedge ref_clk);
    cpu_irq_masked <= 1'b1;
    wait_mode <= 1'b1;
    rd(MCR_OFS_CTRL_STATUS, 8'h03, "status");
    repeat (20) @(posedge ref_clk);
    cpu_irq_masked <= 1'b0;
    #1 flag("irq masked", overflow_irq_q, 1'b0);
    repeat (2) @(posedge ref_clk);
    #1 flag("irq", overflow_irq_q, 1'b1);
    flag("wake", wake_q, 1'b1);
    @(posedge ref_clk);
    wait_mode <= 1'b0;
    rd(MCR_OFS_CTRL_STATUS, 8'h03, "status");
    done("time base");
    wait_rise(t[2]);
    wr(MCR_OFS_CTRL_STATUS, 8'h82);
    rd(MCR_OFS_CTRL_STATUS, 8'h83, "status");
    flag("clk out oe", clk_out_oe_q, 1'b1);
    halt_pulse;
    @(posedge ref_clk);
    #1 flag("active halt", active_halt_q, 1'b1);
    wr(MCR_OFS_BEEP_CTRL, 8'h0c);
    flag("clk out", clk_out_q, 1'b0);
    // Poll off the edge so the halt flag is read settled
    for (int n = 0; n < 40 && active_halt_q === 1'b1; n++) begin
      @(posedge ref_clk);
      #1;
    end
    flag("active halt", active_halt_q, 1'b0);
    rd(MCR_OFS_BEEP_CTRL, 8'h00, "held");
    wr(MCR_OFS_CTRL_STATUS, 8'h00);
    halt_pulse;
    repeat (60) @(posedge ref_clk);
    #1 flag("full halt", full_halt_q, 1'b1);
    flag("wake", wake_q, 1'b0);
    wr(MCR_OFS_BEEP_CTRL, 8'h0c);
    @(posedge ref_clk);
    halt_exit_irq <= 1'b1;
    @(posedge ref_clk);
    halt_exit_irq <= 1'b0;
    repeat (3) @(posedge ref_clk);
    #1 flag("full halt", full_halt_q, 1'b0);
    rd(MCR_OFS_BEEP_CTRL, 8'h00, "frozen");
    done("halt");
    wr(MCR_OFS_BEEP_CTRL, 8'hff);
    rd(MCR_OFS_BEEP_CTRL, 8'h0f, "beep");
    flag("stretch", adc_sample_stretch_q, 1'b1);
    @(posedge ref_clk);
    adc_irq_raw <= 1'b1;
    repeat (2) @(posedge ref_clk);
    #1 flag("adc irq", adc_irq_q, 1'b1);
    for (int c = 1; c < 4; c++) begin
      wr(MCR_OFS_BEEP_CTRL, 8'(c));
      half(h);
      check("half", 8'(h), 8'(THALF[c]));
      flag("beep oe", beep_oe_q, 1'b1);
    end
    flag("adc irq", adc_irq_q, 1'b0);
    wr(MCR_OFS_BEEP_CTRL, 8'h00);
    repeat (2) @(posedge ref_clk);
    #1 flag("beep oe", beep_oe_q, 1'b0);
    done("beep");
    finish_test;
  end
endmodule

// ===== core/mcr_div.sv
// Wrapping counter with registered terminal pulse
`timescale 1ns/10ps
module mcr_div #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             resetn,
  // Control
  input  wire logic             run,
  input  wire logic [WIDTH-1:0] limit,
  // Status
  output logic [WIDTH-1:0]      count_q,
  output logic                  wrap_q
);

  logic at_end;

  // Compare as at-or-above so a lowered limit never runs the count off the top
  assign at_end = (count_q >= limit);

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      count_q <= '0;
    end else if (run) begin
      count_q <= at_end ? '0 : count_q + 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      wrap_q <= 1'b0;
    end else begin
      wrap_q <= run && at_end;
    end
  end

endmodule

// ===== core/mcr_main_clock.sv
// Main clock unit: source select, CPU prescaler, clock out, time base, beeper
`timescale 1ns/10ps

module mcr_main_clock
  import mcr_pkg::*;
#(
  parameter int TB_PERIOD_0 = mcr_pkg::MCR_TB_PERIOD_0,
  parameter int TB_PERIOD_1 = mcr_pkg::MCR_TB_PERIOD_1,
  parameter int TB_PERIOD_2 = mcr_pkg::MCR_TB_PERIOD_2,
  parameter int TB_PERIOD_3 = mcr_pkg::MCR_TB_PERIOD_3,
  parameter int TONE_HALF_1 = mcr_pkg::MCR_TONE_HALF_1,
  parameter int TONE_HALF_2 = mcr_pkg::MCR_TONE_HALF_2,
  parameter int TONE_HALF_3 = mcr_pkg::MCR_TONE_HALF_3
) (
  // Clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 resetn,
  // Register port
  input  wire mcr_pkg::mcr_bus_req_t bus_req,
  output logic [7:0]                rd_data_q,
  // CPU power control
  input  wire logic                 halt_req,
  input  wire logic                 wait_mode,
  input  wire logic                 cpu_irq_masked,
  input  wire logic                 halt_exit_irq,
  // Straps and programming session
  input  wire logic                 pll_option,
  input  wire logic                 in_circuit_programming_session,
  // Converter interrupt in
  input  wire logic                 adc_irq_raw,
  // Clock control outputs
  output logic                      backup_pll_on_q,
  output logic                      clock_detector_q,
  output logic                      clock_source_pick_q,
  output logic                      cpu_tick_q,
  // Clock-out pin
  output logic                      clk_out_q,
  output logic                      clk_out_oe_q,
  // Beep pin
  output logic                      beep_q,
  output logic                      beep_oe_q,
  // Interrupts and power state
  output logic                      overflow_irq_q,
  output logic                      wake_q,
  output logic                      active_halt_q,
  output logic                      full_halt_q,
  // Converter controls
  output logic                      adc_sample_stretch_q,
  output logic                      adc_irq_q
);

  import mcr_pkg::*;

  localparam logic [MCR_TB_WIDTH-1:0] TB_LIM_0 = MCR_TB_WIDTH'(TB_PERIOD_0 - 1);
  localparam logic [MCR_TB_WIDTH-1:0] TB_LIM_1 = MCR_TB_WIDTH'(TB_PERIOD_1 - 1);
  localparam logic [MCR_TB_WIDTH-1:0] TB_LIM_2 = MCR_TB_WIDTH'(TB_PERIOD_2 - 1);
  localparam logic [MCR_TB_WIDTH-1:0] TB_LIM_3 = MCR_TB_WIDTH'(TB_PERIOD_3 - 1);
  localparam logic [MCR_TONE_WIDTH-1:0] TONE_LIM_1 = MCR_TONE_WIDTH'(TONE_HALF_1 - 1);
  localparam logic [MCR_TONE_WIDTH-1:0] TONE_LIM_2 = MCR_TONE_WIDTH'(TONE_HALF_2 - 1);
  localparam logic [MCR_TONE_WIDTH-1:0] TONE_LIM_3 = MCR_TONE_WIDTH'(TONE_HALF_3 - 1);

  // Register fields
  logic       clock_out_on_q;
  logic [1:0] cpu_divider_code_q;
  logic       slow_mode_select_q;
  logic [1:0] time_base_code_q;
  logic       overflow_irq_enable_q;
  logic       overflow_flag_q;
  logic [1:0] tone_select_q;
  logic       adc_irq_enable_q;
  logic       sample_stretch_q;

  // Internal state
  mcr_power_t                  power_q;
  mcr_power_t                  power_d;
  logic [1:0]                  tb_active_q;
  logic [MCR_TB_WIDTH-1:0]     tb_limit;
  logic [MCR_TONE_WIDTH-1:0]   tone_limit;
  logic [MCR_CPU_DIV_WIDTH-1:0] cpu_limit;
  logic                        tb_wrap;
  logic                        tone_wrap;
  logic                        cpu_wrap;
  logic                        icc_seen_q;
  logic                        regs_open;
  logic                        wr_cs;
  logic                        wr_beep;
  logic                        wr_src;
  logic                        rd_cs;
  logic                        irq_cond;
  logic                        pll_on_d;
  logic                        pick_d;
  logic [7:0]                  rd_data_d;

  // Register writes only take effect while the CPU runs
  assign regs_open = (power_q == MCR_RUN);
  assign wr_cs     = bus_req.wr && regs_open && (bus_req.addr == MCR_OFS_CTRL_STATUS);
  assign wr_beep   = bus_req.wr && regs_open && (bus_req.addr == MCR_OFS_BEEP_CTRL);
  assign wr_src    = bus_req.wr && regs_open && (bus_req.addr == MCR_OFS_SOURCE);
  assign rd_cs     = bus_req.rd && (bus_req.addr == MCR_OFS_CTRL_STATUS);

  // Interrupt request condition
  assign irq_cond = overflow_flag_q && overflow_irq_enable_q && !cpu_irq_masked;

  // Control/status register fields
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      clock_out_on_q        <= MCR_RST_CTRL_STATUS[MCR_CS_CLOCK_OUT_ON];
      cpu_divider_code_q    <= MCR_RST_CTRL_STATUS[MCR_CS_CPU_DIV_HI:MCR_CS_CPU_DIV_LO];
      slow_mode_select_q    <= MCR_RST_CTRL_STATUS[MCR_CS_SLOW_MODE];
      time_base_code_q      <= MCR_RST_CTRL_STATUS[MCR_CS_TB_HI:MCR_CS_TB_LO];
      overflow_irq_enable_q <= MCR_RST_CTRL_STATUS[MCR_CS_OVF_IRQ_EN];
    end else if (wr_cs) begin
      clock_out_on_q        <= bus_req.wdata[MCR_CS_CLOCK_OUT_ON];
      cpu_divider_code_q    <= bus_req.wdata[MCR_CS_CPU_DIV_HI:MCR_CS_CPU_DIV_LO];
      slow_mode_select_q    <= bus_req.wdata[MCR_CS_SLOW_MODE];
      time_base_code_q      <= bus_req.wdata[MCR_CS_TB_HI:MCR_CS_TB_LO];
      overflow_irq_enable_q <= bus_req.wdata[MCR_CS_OVF_IRQ_EN];
    end
  end

  // Overflow flag: set at period end, cleared by a read, set wins
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      overflow_flag_q <= MCR_RST_CTRL_STATUS[MCR_CS_OVF_FLAG];
    end else if (tb_wrap) begin
      overflow_flag_q <= 1'b1;
    end else if (rd_cs) begin
      overflow_flag_q <= 1'b0;
    end
  end

  // Beep control register, upper bits never stored
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      sample_stretch_q <= MCR_RST_BEEP_CTRL[MCR_BC_SAMPLE_STRETCH];
      adc_irq_enable_q <= MCR_RST_BEEP_CTRL[MCR_BC_ADC_IRQ_EN];
      tone_select_q    <= MCR_RST_BEEP_CTRL[MCR_BC_TONE_HI:MCR_BC_TONE_LO];
    end else if (wr_beep) begin
      sample_stretch_q <= bus_req.wdata[MCR_BC_SAMPLE_STRETCH];
      adc_irq_enable_q <= bus_req.wdata[MCR_BC_ADC_IRQ_EN];
      tone_select_q    <= bus_req.wdata[MCR_BC_TONE_HI:MCR_BC_TONE_LO];
    end
  end

  // Clock source next values
  always_comb begin
    pll_on_d = backup_pll_on_q;
    pick_d   = clock_source_pick_q;
    if (wr_src) begin
      // PLL stays on while it is the picked source
      pll_on_d = bus_req.wdata[MCR_SRC_PLL_ON] || clock_source_pick_q;
      // PLL can only be picked when it ends up enabled
      pick_d   = bus_req.wdata[MCR_SRC_PICK] && pll_on_d;
    end
    if (in_circuit_programming_session && !icc_seen_q) begin
      pll_on_d = 1'b1;
      pick_d   = 1'b1;
    end
    if (pll_option) begin
      pll_on_d = 1'b1;
      pick_d   = 1'b1;
    end
  end

  // Clock source register
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      backup_pll_on_q     <= MCR_RST_SOURCE[MCR_SRC_PLL_ON];
      clock_detector_q    <= MCR_RST_SOURCE[MCR_SRC_PLL_ON];
      clock_source_pick_q <= MCR_RST_SOURCE[MCR_SRC_PICK];
    end else begin
      backup_pll_on_q     <= pll_on_d;
      clock_detector_q    <= pll_on_d;
      clock_source_pick_q <= pick_d;
    end
  end

  // Session start edge, so software may clear the pick later
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      icc_seen_q <= 1'b0;
    end else begin
      icc_seen_q <= in_circuit_programming_session;
    end
  end

  // Power state
  always_comb begin
    power_d = power_q;
    unique case (power_q)
      MCR_RUN: begin
        if (halt_req) begin
          power_d = overflow_irq_enable_q ? MCR_ACTIVE_HALT : MCR_FULL_HALT;
        end
      end
      MCR_ACTIVE_HALT: begin
        if (irq_cond || halt_exit_irq) begin
          power_d = MCR_RUN;
        end
      end
      MCR_FULL_HALT: begin
        if (halt_exit_irq) begin
          power_d = MCR_RUN;
        end
      end
      default: power_d = MCR_RUN;
    endcase
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      power_q <= MCR_RUN;
    end else begin
      power_q <= power_d;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      active_halt_q <= 1'b0;
      full_halt_q   <= 1'b0;
    end else begin
      active_halt_q <= (power_d == MCR_ACTIVE_HALT);
      full_halt_q   <= (power_d == MCR_FULL_HALT);
    end
  end

  // Wake-up request out of wait or halt
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      wake_q <= 1'b0;
    end else begin
      unique case (power_q)
        MCR_RUN:         wake_q <= wait_mode && irq_cond;
        MCR_ACTIVE_HALT: wake_q <= irq_cond || halt_exit_irq;
        MCR_FULL_HALT:   wake_q <= halt_exit_irq;
        default:         wake_q <= 1'b0;
      endcase
    end
  end

  // Time base: period taken from the code latched at each wrap
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      tb_active_q <= MCR_RST_CTRL_STATUS[MCR_CS_TB_HI:MCR_CS_TB_LO];
    end else if (tb_wrap) begin
      tb_active_q <= time_base_code_q;
    end
  end

  always_comb begin
    unique case (tb_active_q)
      2'h0: tb_limit = TB_LIM_0;
      2'h1: tb_limit = TB_LIM_1;
      2'h2: tb_limit = TB_LIM_2;
      2'h3: tb_limit = TB_LIM_3;
    endcase
  end

  // Counter runs in wait and active halt, frozen in full halt
  mcr_div #(.WIDTH(MCR_TB_WIDTH)) u_time_base (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .run     (power_q != MCR_FULL_HALT),
    .limit   (tb_limit),
    .count_q (),
    .wrap_q  (tb_wrap)
  );

  // Interrupt output
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      overflow_irq_q <= 1'b0;
    end else begin
      overflow_irq_q <= irq_cond;
    end
  end

  // CPU prescaler: divide by 2 to 16 in slow mode
  assign cpu_limit = MCR_CPU_DIV_WIDTH'((5'h02 << cpu_divider_code_q) - 5'h01);

  mcr_div #(.WIDTH(MCR_CPU_DIV_WIDTH)) u_cpu_div (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .run     (regs_open),
    .limit   (cpu_limit),
    .count_q (),
    .wrap_q  (cpu_wrap)
  );

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cpu_tick_q <= 1'b0;
    end else if (!regs_open) begin
      cpu_tick_q <= 1'b0;
    end else begin
      cpu_tick_q <= slow_mode_select_q ? cpu_wrap : 1'b1;
    end
  end

  // Clock-out pin
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      clk_out_q    <= 1'b0;
      clk_out_oe_q <= 1'b0;
    end else begin
      clk_out_oe_q <= clock_out_on_q;
      if (clock_out_on_q && regs_open) begin
        clk_out_q <= !clk_out_q;
      end else begin
        clk_out_q <= 1'b0;
      end
    end
  end

  // Beeper half-period select
  always_comb begin
    unique case (tone_select_q)
      2'h1:    tone_limit = TONE_LIM_1;
      2'h2:    tone_limit = TONE_LIM_2;
      2'h3:    tone_limit = TONE_LIM_3;
      default: tone_limit = '0;
    endcase
  end

  mcr_div #(.WIDTH(MCR_TONE_WIDTH)) u_tone (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .run     ((tone_select_q != 2'h0) && (power_q != MCR_FULL_HALT)),
    .limit   (tone_limit),
    .count_q (),
    .wrap_q  (tone_wrap)
  );

  // Tone pin, half period per wrap for even duty
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      beep_q    <= 1'b0;
      beep_oe_q <= 1'b0;
    end else begin
      beep_oe_q <= (tone_select_q != 2'h0);
      if (tone_select_q == 2'h0) begin
        beep_q <= 1'b0;
      end else if (tone_wrap) begin
        beep_q <= !beep_q;
      end
    end
  end

  // Converter controls
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      adc_sample_stretch_q <= 1'b0;
      adc_irq_q            <= 1'b0;
    end else begin
      adc_sample_stretch_q <= sample_stretch_q;
      adc_irq_q            <= adc_irq_raw && adc_irq_enable_q;
    end
  end

  // Read mux, unmapped reads return zero
  always_comb begin
    rd_data_d = 8'h00;
    unique case (bus_req.addr)
      MCR_OFS_CTRL_STATUS: rd_data_d = {clock_out_on_q, cpu_divider_code_q, slow_mode_select_q,
                                        time_base_code_q, overflow_irq_enable_q,
                                        overflow_flag_q};
      MCR_OFS_BEEP_CTRL:   rd_data_d = {4'h0, sample_stretch_q, adc_irq_enable_q,
                                        tone_select_q};
      MCR_OFS_SOURCE:      rd_data_d = {4'h0, backup_pll_on_q, 1'b0, clock_source_pick_q, 1'b0};
      default:             rd_data_d = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rd_data_q <= 8'h00;
    end else if (bus_req.rd) begin
      rd_data_q <= rd_data_d;
    end else begin
      rd_data_q <= 8'h00;
    end
  end

endmodule

// ===== core/mcr_pkg.sv
// Package for the main clock unit: register map, field layout, timing constants
package mcr_pkg;

  // Register offsets
  localparam logic [7:0] MCR_OFS_CTRL_STATUS = 8'h2c;
  localparam logic [7:0] MCR_OFS_BEEP_CTRL   = 8'h2d;
  localparam logic [7:0] MCR_OFS_SOURCE      = 8'h40;

  // Reset values
  localparam logic [7:0] MCR_RST_CTRL_STATUS = 8'h00;
  localparam logic [7:0] MCR_RST_BEEP_CTRL   = 8'h00;
  localparam logic [7:0] MCR_RST_SOURCE      = 8'h00;

  // Control/status field positions
  localparam int MCR_CS_CLOCK_OUT_ON = 7;
  localparam int MCR_CS_CPU_DIV_HI   = 6;
  localparam int MCR_CS_CPU_DIV_LO   = 5;
  localparam int MCR_CS_SLOW_MODE    = 4;
  localparam int MCR_CS_TB_HI        = 3;
  localparam int MCR_CS_TB_LO        = 2;
  localparam int MCR_CS_OVF_IRQ_EN   = 1;
  localparam int MCR_CS_OVF_FLAG     = 0;

  // Beep control field positions
  localparam int MCR_BC_SAMPLE_STRETCH = 3;
  localparam int MCR_BC_ADC_IRQ_EN     = 2;
  localparam int MCR_BC_TONE_HI        = 1;
  localparam int MCR_BC_TONE_LO        = 0;

  // Clock source field positions
  localparam int MCR_SRC_PLL_ON = 3;
  localparam int MCR_SRC_PICK   = 1;

  // Time-base periods in oscillator-clock cycles
  localparam int MCR_TB_PERIOD_0 = 16000;
  localparam int MCR_TB_PERIOD_1 = 32000;
  localparam int MCR_TB_PERIOD_2 = 80000;
  localparam int MCR_TB_PERIOD_3 = 200000;
  localparam int MCR_TB_WIDTH    = 18;

  // Beeper tones, referred to the undivided oscillator clock
  localparam int MCR_OSC_HZ       = 8000000;
  localparam int MCR_TONE_HZ_1    = 2000;
  localparam int MCR_TONE_HZ_2    = 1000;
  localparam int MCR_TONE_HZ_3    = 500;
  localparam int MCR_TONE_HALF_1  = MCR_OSC_HZ / (2 * MCR_TONE_HZ_1);
  localparam int MCR_TONE_HALF_2  = MCR_OSC_HZ / (2 * MCR_TONE_HZ_2);
  localparam int MCR_TONE_HALF_3  = MCR_OSC_HZ / (2 * MCR_TONE_HZ_3);
  localparam int MCR_TONE_WIDTH   = 13;

  // Slow-mode divider counter width
  localparam int MCR_CPU_DIV_WIDTH = 4;

  // Register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } mcr_bus_req_t;

  // Power state of the unit
  typedef enum logic [2:0] {
    MCR_RUN         = 3'b001,
    MCR_ACTIVE_HALT = 3'b010,
    MCR_FULL_HALT   = 3'b100
  } mcr_power_t;

endpackage
